// *** design/fl_attr_pkg.sv ***
/*
 * Constants and carrier types for the first-stage control decode block of a
 * remapping context entry (entry bits 95..135), plus its register map.
 * Assumes an Avalon-MM slave bus with 32-bit data and word-aligned offsets.
 */
package fl_attr_pkg;
  // entry bit positions
  localparam int unsigned POS_MARK = 135;
  localparam int unsigned POS_SUP_EXEC = 134;
  localparam int unsigned POS_NX = 133;
  localparam int unsigned POS_WP = 132;
  localparam int unsigned POS_DEPTH = 130;
  localparam int unsigned POS_EXEC_EN = 129;
  localparam int unsigned POS_SUP_EN = 128;
  localparam int unsigned POS_ATTR = 96;
  localparam int unsigned POS_CD = 95;
  localparam int unsigned POS_WT = 94;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned SLOTS = 8;
  // translation types
  localparam logic [2:0] TT_STAGE2 = 3'h2;
  localparam logic [2:0] TT_PASS = 3'h4;
  // depth codes
  localparam logic [1:0] DEPTH_FOUR = 2'h0;
  localparam logic [1:0] DEPTH_FIVE = 2'h1;
  // memory types
  localparam logic [3:0] MT_UC = 4'h0;
  localparam logic [3:0] MT_WC = 4'h1;
  localparam logic [3:0] MT_WT = 4'h4;
  localparam logic [3:0] MT_WP = 4'h5;
  localparam logic [3:0] MT_WB = 4'h6;
  localparam logic [3:0] MT_UCM = 4'h7;
  // register word offsets (byte addresses)
  localparam logic [5:0] OFS_ENTRY0 = 6'h00; // entry bits 95..126
  localparam logic [5:0] OFS_ENTRY1 = 6'h04; // entry bits 127..135 in low 9
  localparam logic [5:0] OFS_CAPS = 6'h08;
  localparam logic [5:0] OFS_REQ = 6'h0C;
  localparam logic [5:0] OFS_RESULT = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_MASK = 6'h18;
  // caps bits
  localparam int unsigned CAP_EA = 0;
  localparam int unsigned CAP_FS = 1;
  localparam int unsigned CAP_5L = 2;
  localparam int unsigned CAP_EX = 3;
  localparam int unsigned CAP_SUP = 4;
  localparam int unsigned CAP_MT = 5;
  // status bits
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_FAULT = 1;
  localparam int unsigned ST_RSVD = 2;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [5:0] CAPS_RST = 6'h3F;

  // a request as written to the request register
  typedef struct packed {
    logic [2:0] slot;      // 20:18 attribute slot index of the leaf
    logic [2:0] tt;        // 17:15 translation type
    logic coherent;        // 14
    logic xd;              // 13 execute-disable seen in leaf path
    logic all_user;        // 12 every first-stage level has user flag
    logic read_only;       // 11
    logic read_ok;         // 10
    logic supervisor;      // 9
    logic exec;            // 8
    logic write;           // 7
    logic pasid;           // 6
    logic present;         // 5
    logic [4:0] spare;     // 4:0
  } req_type;

  typedef struct packed {
    logic [3:0] root_mt;   // 15:12
    logic [3:0] leaf_mt;   // 11:8
    logic five_level;      // 7
    logic mark_ea;         // 6
    logic mt_valid;        // 5
    logic slot_rsvd;       // 4
    logic rsvd_fault;      // 3
    logic sup_fault;       // 2
    logic exec_fault;      // 1
    logic perm_fault;      // 0
  } result_type;
endpackage

// *** design/fl_attr_decode.sv ***
/*
 * First-stage control decode: holds the 41 control bits of an entry,
 * evaluates one request at a time and answers with permission and memory
 * type. Assumes an Avalon-MM master that holds requests until waitrequest
 * is low; page walking and fault recording live elsewhere.
 */
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module fl_attr_decode (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic ea_mark_o,
  output logic fault_o
);
  typedef enum logic [1:0] {IDLE, EVAL, ANSWER} state_type;
  state_type state_q, state_d;

  logic [31:0] entry0_q;
  logic [8:0] entry1_q;
  logic [5:0] caps_q;
  fl_attr_pkg::req_type req_q;
  fl_attr_pkg::result_type res_q;
  logic [2:0] status_q, mask_q;
  logic [31:0] rdata_q;
  logic wait_q, irq_q, mark_q, fault_q;

  // entry view at its own bit numbers 95..135
  logic [135:95] ent;
  assign ent = {entry1_q, entry0_q};

  wire ea_sup = caps_q[fl_attr_pkg::CAP_EA];
  wire fs_sup = caps_q[fl_attr_pkg::CAP_FS];
  wire five_sup = caps_q[fl_attr_pkg::CAP_5L];
  wire ex_sup = caps_q[fl_attr_pkg::CAP_EX];
  wire sup_sup = caps_q[fl_attr_pkg::CAP_SUP];
  wire mt_sup = caps_q[fl_attr_pkg::CAP_MT];

  wire ext_accessed_mark_enable = ent[fl_attr_pkg::POS_MARK];
  wire supervisor_exec_from_user_block = ent[fl_attr_pkg::POS_SUP_EXEC];
  wire no_execute_enable = ent[fl_attr_pkg::POS_NX];
  wire write_protect_enable = ent[fl_attr_pkg::POS_WP];
  wire [1:0] first_stage_paging_depth = ent[fl_attr_pkg::POS_DEPTH +: 2];
  wire execute_request_enable = ent[fl_attr_pkg::POS_EXEC_EN];
  wire supervisor_request_enable = ent[fl_attr_pkg::POS_SUP_EN];
  wire [31:0] page_attribute_slots = ent[fl_attr_pkg::POS_ATTR +: 32];
  wire root_cache_disable = ent[fl_attr_pkg::POS_CD];
  // entry bit 94 lies below the held view, so root write-through reads as clear
  wire root_write_through = 1'b0;

  // write-protect, no-execute, supervisor-exec and mark bits have no effect for stage-two-only or pass-through
  wire fs_used = (req_q.tt != fl_attr_pkg::TT_STAGE2) && (req_q.tt != fl_attr_pkg::TT_PASS);

  // reserved-field checks; depth 01 without five-level support is a software slip
  wire rsvd_ea = !ea_sup && ext_accessed_mark_enable;
  wire rsvd_fs = !fs_sup && (|ent[135:130]);
  wire rsvd_depth = fs_sup && (first_stage_paging_depth[1] ||
    (!five_sup && first_stage_paging_depth == fl_attr_pkg::DEPTH_FIVE));
  wire rsvd_ex = !ex_sup && execute_request_enable;
  wire rsvd_sup = !sup_sup && supervisor_request_enable;
  wire rsvd_mt = !mt_sup && ((|page_attribute_slots) || root_cache_disable
    || root_write_through);
  wire rsvd_any = req_q.present && (rsvd_ea || rsvd_fs || rsvd_depth || rsvd_ex
    || rsvd_sup || rsvd_mt);

  // eight slots, four bits each, slot zero at the low end
  logic [3:0] slot_code [fl_attr_pkg::SLOTS];
  logic [fl_attr_pkg::SLOTS-1:0] slot_bad;
  genvar gi;
  generate
    for (gi = 0; gi < fl_attr_pkg::SLOTS; gi++) begin : g_slot
      assign slot_code[gi] = page_attribute_slots[gi*fl_attr_pkg::SLOT_W +: fl_attr_pkg::SLOT_W];
      assign slot_bad[gi] = slot_code[gi][3] || (slot_code[gi][2:1] == 2'h1);
    end
  endgenerate
  wire attribute_slot_zero_bad = slot_bad[0];
  wire [3:0] leaf_code = slot_code[req_q.slot];
  wire leaf_rsvd = slot_bad[req_q.slot];

  // permission checks
  wire exec_gate = req_q.pasid && req_q.exec && !execute_request_enable;
  wire sup_gate = req_q.supervisor && !supervisor_request_enable;
  wire sup_exec = fs_used && supervisor_exec_from_user_block && req_q.supervisor
    && req_q.exec && req_q.all_user;
  // without no-execute, read permission is enough to fetch
  wire nx_block = req_q.exec && (!req_q.read_ok ||
    (fs_used && no_execute_enable && req_q.xd));
  // clear write-protect lets supervisor write read-only pages
  wire wp_block = req_q.write && req_q.read_only &&
    (!req_q.supervisor || (fs_used && write_protect_enable));
  wire perm_bad = sup_exec || nx_block || wp_block;
  wire any_fault = rsvd_any || exec_gate || sup_gate || perm_bad;

  // root-level fetch type: cache-disable or write-through picks UC, else WB
  wire [3:0] root_mt = (root_cache_disable || root_write_through) ?
    fl_attr_pkg::MT_UC : fl_attr_pkg::MT_WB;
  wire mt_ok = mt_sup && req_q.coherent;

  fl_attr_pkg::result_type res_d;
  always_comb begin
    res_d = '0;
    res_d.perm_fault = perm_bad && !rsvd_any;
    res_d.exec_fault = exec_gate;
    res_d.sup_fault = sup_gate;
    res_d.rsvd_fault = rsvd_any;
    res_d.slot_rsvd = mt_ok && leaf_rsvd;
    res_d.mt_valid = mt_ok && !leaf_rsvd && !any_fault;
    res_d.leaf_mt = mt_ok ? leaf_code : fl_attr_pkg::MT_UC;
    res_d.root_mt = mt_ok ? root_mt : fl_attr_pkg::MT_UC;
    res_d.five_level = first_stage_paging_depth == fl_attr_pkg::DEPTH_FIVE;
    res_d.mark_ea = fs_used && ea_sup && ext_accessed_mark_enable && !any_fault;
  end

  // bus decode
  wire wr = avs_write_i && wait_q;
  wire rd = avs_read_i && wait_q;
  wire wr_entry0 = wr && avs_address_i == fl_attr_pkg::OFS_ENTRY0;
  wire wr_entry1 = wr && avs_address_i == fl_attr_pkg::OFS_ENTRY1;
  wire wr_caps = wr && avs_address_i == fl_attr_pkg::OFS_CAPS;
  wire wr_req = wr && avs_address_i == fl_attr_pkg::OFS_REQ && state_q == IDLE;
  wire wr_status = wr && avs_address_i == fl_attr_pkg::OFS_STATUS;
  wire wr_mask = wr && avs_address_i == fl_attr_pkg::OFS_MASK;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address_i)
      fl_attr_pkg::OFS_ENTRY0: rd_mux = entry0_q;
      fl_attr_pkg::OFS_ENTRY1: rd_mux = {23'h0, entry1_q};
      fl_attr_pkg::OFS_CAPS: rd_mux = {26'h0, caps_q};
      fl_attr_pkg::OFS_REQ: rd_mux = {11'h0, req_q};
      fl_attr_pkg::OFS_RESULT: rd_mux = {16'h0, res_q};
      fl_attr_pkg::OFS_STATUS: rd_mux = {29'h0, status_q};
      fl_attr_pkg::OFS_MASK: rd_mux = {29'h0, mask_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // evaluation sequence: request write -> EVAL (one cycle) -> ANSWER
  always_comb begin
    unique case (state_q)
      IDLE: state_d = wr_req ? EVAL : IDLE;
      EVAL: state_d = ANSWER;
      ANSWER: state_d = IDLE;
    endcase
  end

  logic any_fault_q;
  wire ev_done = state_q == ANSWER;
  wire [2:0] events = {res_q.rsvd_fault, any_fault_q, 1'b1} & {3{ev_done}};
  // a new event wins over a write-one clear in the same cycle
  wire [2:0] status_d = (status_q & ~(wr_status ? avs_writedata_i[2:0] : 3'h0)) | events;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= IDLE;
      entry0_q <= 32'h0;
      entry1_q <= 9'h0;
      caps_q <= fl_attr_pkg::CAPS_RST;
      req_q <= '0;
      res_q <= '0;
      any_fault_q <= 1'b0;
      status_q <= fl_attr_pkg::STATUS_RST;
      mask_q <= fl_attr_pkg::MASK_RST;
      rdata_q <= 32'h0;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
      mark_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_entry0) entry0_q <= avs_writedata_i;
      if (wr_entry1) entry1_q <= avs_writedata_i[8:0];
      if (wr_caps) caps_q <= avs_writedata_i[5:0];
      if (wr_req) req_q <= avs_writedata_i[20:0];
      if (state_q == EVAL) begin
        res_q <= res_d;
        any_fault_q <= any_fault;
      end
      status_q <= status_d;
      if (wr_mask) mask_q <= avs_writedata_i[2:0];
      if (rd) rdata_q <= rd_mux;
      // one wait cycle per access; request write during evaluation stalls
      wait_q <= !(avs_read_i || avs_write_i) || !wait_q ||
        (avs_address_i == fl_attr_pkg::OFS_REQ && avs_write_i && state_q != IDLE) ?
        1'b1 : 1'b0;
      irq_q <= |(status_d & mask_q);
      mark_q <= ev_done && res_q.mark_ea;
      fault_q <= ev_done && any_fault_q;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign ea_mark_o = mark_q;
  assign fault_o = fault_q;

  // assertions
  wait_low_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low twice");
  mark_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ea_mark_o |-> $past(res_q.mark_ea) && caps_q[fl_attr_pkg::CAP_EA])
    else $error("mark without enable");
  mark_fault_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(ea_mark_o && fault_o)) else $error("mark and fault together");
  ignore_s2_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && !fs_used |=> !res_q.mark_ea) else $error("first-stage bit used");
  sup_exec_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && sup_exec |=> ##1 fault_o) else $error("supervisor exec not faulted");
  nx_off_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && req_q.exec && req_q.read_ok && !no_execute_enable && !sup_exec
    && !req_q.write
    |=> !res_q.perm_fault) else $error("fetch denied with nx clear");
  wp_off_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && !write_protect_enable && req_q.supervisor && !req_q.exec
    |=> !res_q.perm_fault) else $error("supervisor write blocked");
  wp_on_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && fs_used && write_protect_enable && req_q.write && req_q.read_only
    |=> ##1 fault_o) else $error("read-only write allowed");
  exec_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && exec_gate |=> res_q.exec_fault ##1 fault_o)
    else $error("execute request not faulted");
  sup_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_q == EVAL && sup_gate |=> ##1 fault_o) else $error("supervisor not faulted");
  root_mt_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    res_q.root_mt == fl_attr_pkg::MT_UC || res_q.root_mt == fl_attr_pkg::MT_WB)
    else $error("root type reserved");
  mt_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    res_q.mt_valid |-> caps_q[fl_attr_pkg::CAP_MT] && req_q.coherent)
    else $error("memory type outside coherent domain");
  irq_lvl_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    |(status_q & mask_q) |-> irq_o || $rose(|(status_q & mask_q)))
    else $error("irq missing");

  cov_fault_c: cover property (@(posedge core_clk_i) fault_o);
  cov_mark_c: cover property (@(posedge core_clk_i) ea_mark_o);
  cov_five_c: cover property (@(posedge core_clk_i) res_q.five_level && res_q.mt_valid);
  cov_irq_c: cover property (@(posedge core_clk_i) irq_o);
endmodule // fl_attr_decode

// *** sim/avl_host_model.sv ***
/*
 * Register bus host model: stands for the software that programs the
 * decode block over Avalon-MM.
 * Assumes the same clock as the block and a slave that answers with
 * waitrequest low for one cycle.
 */
`timescale 1ns/1ps
module avl_host_model (
  input wire logic core_clk_i,
  output logic [5:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  initial begin
    address_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end

  // the whole request stays put until waitrequest is seen low at an edge
  task automatic access(input logic [5:0] a, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge core_clk_i);
    address_o <= a;
    read_o <= !wr;
    write_o <= wr;
    writedata_o <= d;
    do @(posedge core_clk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // released data must not look like the last value
    writedata_o <= ~d;
  endtask
endmodule // avl_host_model

// *** sim/tb_top.sv ***
/*
 * Self-checking bench for the first-stage control decode block: registers,
 * permission decisions, memory types and the interrupt.
 * Assumes avl_host_model drives the register bus.
 */
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitrequest;
  logic irq;
  logic ea_mark;
  logic fault;
  logic [31:0] res;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_fault = 0;
  int n_mark = 0;

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  fl_attr_decode u_fl_attr_decode (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitrequest),
    .irq_o(irq), .ea_mark_o(ea_mark), .fault_o(fault));

  avl_host_model u_avl_host_model (.core_clk_i(core_clk_i), .address_o(address),
    .read_o(read), .write_o(write), .writedata_o(wdata), .readdata_i(rdata),
    .waitrequest_i(waitrequest));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // about forty evaluations of under twenty cycles each fit well below this
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (fault === 1'b1) n_fault <= n_fault + 1;
    if (ea_mark === 1'b1) n_mark <= n_mark + 1;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end

  function automatic logic [40:0] b(input int unsigned p);
    return 41'h1 << (p - 95);
  endfunction

  // f = {exec, write, supervisor, read_only, xd, all_user}
  function automatic fl_attr_pkg::req_type q(input logic [5:0] f, input logic [2:0] tt);
    fl_attr_pkg::req_type r;
    r = '0;
    r.present = 1'b1;
    r.pasid = 1'b1;
    r.read_ok = 1'b1;
    r.coherent = 1'b1;
    r.tt = tt;
    {r.exec, r.write, r.supervisor, r.read_only, r.xd, r.all_user} = f;
    return r;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q0;
    u_avl_host_model.access(a, 1'b1, d, q0);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    u_avl_host_model.access(a, 1'b0, 32'h0, d);
  endtask

  // ef 2 leaves the fault outcome unchecked
  task automatic eval(input logic [40:0] e, input fl_attr_pkg::req_type r, input int ef);
    int f0;
    f0 = n_fault;
    wr(fl_attr_pkg::OFS_ENTRY0, e[31:0]);
    wr(fl_attr_pkg::OFS_ENTRY1, {23'h0, e[40:32]});
    wr(fl_attr_pkg::OFS_REQ, {11'h0, r});
    repeat (4) @(posedge core_clk_i);
    rd(fl_attr_pkg::OFS_RESULT, res);
    if (ef < 2) begin
      check(32'(n_fault - f0), 32'(ef));
      check({31'h0, |res[3:0]}, 32'(ef));
    end
  endtask

  task automatic row(input logic [40:0] e, input logic [5:0] f, input logic [2:0] tt,
                     input int ef);
    eval(e, q(f, tt), ef);
  endtask

  initial begin
    logic [31:0] d;
    logic [40:0] base;
    logic [40:0] wp;
    logic [40:0] nx;
    logic [40:0] sx;
    logic [40:0] mk;
    fl_attr_pkg::req_type r;
    int m0;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    base = b(fl_attr_pkg::POS_SUP_EN) | b(fl_attr_pkg::POS_EXEC_EN);
    wp = base | b(fl_attr_pkg::POS_WP);
    nx = base | b(fl_attr_pkg::POS_NX);
    sx = base | b(fl_attr_pkg::POS_SUP_EXEC);
    mk = base | b(fl_attr_pkg::POS_MARK);
    rd(fl_attr_pkg::OFS_CAPS, d);
    check(d, {26'h0, fl_attr_pkg::CAPS_RST});
    rd(fl_attr_pkg::OFS_STATUS, d);
    check(d, {29'h0, fl_attr_pkg::STATUS_RST});
    rd(fl_attr_pkg::OFS_MASK, d);
    check(d, {29'h0, fl_attr_pkg::MASK_RST});
    wr(6'h1C, 32'hFFFFFFFF);
    rd(6'h1C, d);
    check(d, 32'h0);
    $display("test registers done");
    row(base, 6'b100010, 3'h1, 0);
    row(nx, 6'b100010, 3'h1, 1);
    row(base ^ b(fl_attr_pkg::POS_EXEC_EN), 6'b100000, 3'h1, 1);
    row(base ^ b(fl_attr_pkg::POS_SUP_EN), 6'b001000, 3'h1, 1);
    row(sx, 6'b101001, 3'h1, 1);
    row(base, 6'b101001, 3'h1, 0);
    row(base, 6'b011100, 3'h1, 0);
    row(wp, 6'b011100, 3'h1, 1);
    row(wp, 6'b011100, fl_attr_pkg::TT_STAGE2, 0);
    row(nx, 6'b100010, fl_attr_pkg::TT_PASS, 0);
    row(sx, 6'b101001, fl_attr_pkg::TT_STAGE2, 0);
    $display("test permissions done");
    m0 = n_mark;
    row(mk, 6'h0, 3'h1, 0);
    check({31'h0, res[6]}, 32'h1);
    check(32'(n_mark - m0), 32'h1);
    row(mk, 6'h0, fl_attr_pkg::TT_PASS, 0);
    check({31'h0, res[6]}, 32'h0);
    row(base | b(fl_attr_pkg::POS_DEPTH), 6'h0, 3'h1, 0);
    check({31'h0, res[7]}, 32'h1);
    row(base, 6'h0, 3'h1, 0);
    check({31'h0, res[7]}, 32'h0);
    row(base | (b(fl_attr_pkg::POS_DEPTH) << 1), 6'h0, 3'h1, 1);
    check({31'h0, res[3]}, 32'h1);
    wr(fl_attr_pkg::OFS_CAPS, 32'h3F & ~(32'h1 << fl_attr_pkg::CAP_EA));
    row(mk, 6'h0, 3'h1, 1);
    check({31'h0, res[3]}, 32'h1);
    wr(fl_attr_pkg::OFS_CAPS, 32'h3F & ~(32'h1 << fl_attr_pkg::CAP_FS));
    row(wp, 6'h0, 3'h1, 1);
    check({31'h0, res[3]}, 32'h1);
    wr(fl_attr_pkg::OFS_CAPS, {26'h0, fl_attr_pkg::CAPS_RST});
    $display("test controls done");
    for (int c = 0; c < 16; c++) begin
      r = q(6'h0, 3'h1);
      r.slot = 3'(c % 8);
      eval(base | (41'(c) << (1 + 4 * (c % 8))), r, 2);
      check({28'h0, res[11:8]}, 32'(c));
      check({31'h0, res[4]}, 32'(c inside {2, 3} || c > 7));
      check({31'h0, res[5]}, 32'(!(c inside {2, 3} || c > 7)));
    end
    r = q(6'h0, 3'h1);
    r.coherent = 1'b0;
    eval(base, r, 0);
    check({31'h0, res[5]}, 32'h0);
    row(base | b(fl_attr_pkg::POS_CD), 6'h0, 3'h1, 0);
    check({28'h0, res[15:12]}, {28'h0, fl_attr_pkg::MT_UC});
    row(base, 6'h0, 3'h1, 0);
    check({28'h0, res[15:12]}, {28'h0, fl_attr_pkg::MT_WB});
    $display("test memory types done");
    wr(fl_attr_pkg::OFS_STATUS, 32'h7);
    row(wp, 6'b011100, 3'h1, 1);
    rd(fl_attr_pkg::OFS_STATUS, d);
    check(d & 32'h3, 32'h3);
    check({31'h0, irq}, 32'h0);
    wr(fl_attr_pkg::OFS_MASK, 32'h2);
    rd(fl_attr_pkg::OFS_STATUS, d);
    check({31'h0, irq}, 32'h1);
    wr(fl_attr_pkg::OFS_STATUS, 32'h2);
    rd(fl_attr_pkg::OFS_STATUS, d);
    check(d & 32'h2, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    summarize();
  end
endmodule // tb_top
